/* rtl/fsfc_top.sv */
// fsfc_top: flash control, security register and fuse programming
// assumes internal register space at 8-bit addresses, external data space at 16-bit
`timescale 1ns/1ns
module fsfc_top
  import fsfc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire fsfc_acc_s   sfr_i,
  input  wire fsfc_acc_s   xdata_i,
  input  wire logic        int_enabled_i,
  input  wire logic        sec_pin_i,
  input  wire logic        code_fuse_blown_i,
  input  wire logic        debug_fuse_blown_i,
  input  wire logic        ext_rd_req_i,
  input  wire logic        dbg_wr_i,
  input  wire logic [15:0] dbg_addr_i,
  input  wire logic [7:0]  dbg_data_i,
  output logic [7:0]       sfr_rdata_o,
  output logic [7:0]       xdata_rdata_o,
  output logic             xram_wr_o,
  output fsfc_flash_s      flash_o,
  output logic             dbg_prog_o,
  output logic             ext_rd_grant_o,
  output logic             burn_code_o,
  output logic             burn_debug_o
);
  logic       pwe_reg;
  logic       meen_reg;
  logic       lock_reg;
  logic       perm_reg;
  logic [1:0] fuse_stat_reg;
  logic       fc_wr;
  logic       setup_wr;
  logic       pulse_wr;
  logic       sec_wr;
  logic       in_xsfr;
  logic       store;
  logic       cpu_prog;
  logic       erase_reg;
  logic [15:0] flash_addr_reg;
  logic [7:0] flash_data_reg;

  assign in_xsfr  = xdata_i.addr >= XSFR_BASE && xdata_i.addr <= XSFR_TOP;
  assign fc_wr    = sfr_i.wr && sfr_i.addr[7:0] == FLASH_CONTROL_ADDR;
  assign setup_wr = xdata_i.wr && in_xsfr && xdata_i.addr == FUSE_SETUP_ADDR;
  assign pulse_wr = xdata_i.wr && in_xsfr && xdata_i.addr == FUSE_BURN_PULSE_ADDR;
  assign sec_wr   = xdata_i.wr && in_xsfr && xdata_i.addr == SECURITY_ADDR;
  assign store    = xdata_i.wr && !in_xsfr;

  // program write enable
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwe_reg <= REG_RESET[FC_PWE_BIT];
    end else if (fc_wr && !int_enabled_i) begin
      pwe_reg <= sfr_i.wdata[FC_PWE_BIT];
    end else if (store && pwe_reg) begin
      pwe_reg <= 1'b0;
    end
  end

  // mass erase enable, consumed by one erase pulse
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meen_reg <= REG_RESET[FC_MEEN_BIT];
    end else begin
      meen_reg <= fc_wr && sfr_i.wdata[FC_MEEN_BIT];
    end
  end

  // lock bit
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_reg <= REG_RESET[FC_LOCK_BIT];
    end else if (fc_wr && sfr_i.wdata[FC_LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  // security register control and fuse status
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      perm_reg      <= REG_RESET[SEC_PERM_BIT];
      fuse_stat_reg <= REG_RESET[1:0];
    end else begin
      if (sec_wr) begin
        perm_reg <= xdata_i.wdata[SEC_PERM_BIT];
      end
      // fuse status bits, a blown fuse wins over a write
      if (sec_wr) begin
        fuse_stat_reg <= xdata_i.wdata[1:0] | {debug_fuse_blown_i, code_fuse_blown_i};
      end else begin
        fuse_stat_reg <= fuse_stat_reg | {debug_fuse_blown_i, code_fuse_blown_i};
      end
    end
  end

  // internal space read data; unmapped reads return zero
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sfr_rdata_o <= REG_RESET;
    end else if (sfr_i.rd) begin
      if (sfr_i.addr[7:0] == FLASH_CONTROL_ADDR) begin
        sfr_rdata_o <= {1'b0, lock_reg, 5'h00, pwe_reg};
      end else begin
        sfr_rdata_o <= UNMAPPED_READ;
      end
    end
  end

  // external space read data for the security register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xdata_rdata_o <= REG_RESET;
    end else if (xdata_i.rd) begin
      if (in_xsfr && xdata_i.addr == SECURITY_ADDR) begin
        xdata_rdata_o <= {2'h0, sec_pin_i, 3'h0, fuse_stat_reg};
      end else begin
        xdata_rdata_o <= UNMAPPED_READ;
      end
    end
  end

  // RAM writes and flash strobes
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xram_wr_o      <= 1'b0;
      flash_addr_reg <= 16'h0000;
      flash_data_reg <= 8'h00;
      erase_reg      <= 1'b0;
    end else begin
      // stores go to RAM unless enabled
      xram_wr_o <= store && !pwe_reg;
      erase_reg <= meen_reg;
      if (store) begin
        flash_addr_reg <= xdata_i.addr;
        flash_data_reg <= xdata_i.wdata;
      end
    end
  end

  // flash port, one driver for the whole struct, every field from a flip-flop
  assign flash_o = '{prog: cpu_prog, mass_erase: erase_reg, addr: flash_addr_reg,
                     data: flash_data_reg};

  // external read grant
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_rd_grant_o <= 1'b0;
    end else begin
      ext_rd_grant_o <= ext_rd_req_i && !lock_reg;
    end
  end

  fsfc_flash_gate u_gate (
    .sys_clk_i    (sys_clk_i),
    .resetn_i     (resetn_i),
    .pwe_i        (pwe_reg),
    .lock_i       (lock_reg),
    .store_i      (store),
    .store_addr_i (xdata_i.addr),
    .store_data_i (xdata_i.wdata),
    .dbg_wr_i     (dbg_wr_i),
    .dbg_addr_i   (dbg_addr_i),
    .dbg_data_i   (dbg_data_i),
    .cpu_prog_o   (cpu_prog),
    .dbg_prog_o   (dbg_prog_o)
  );

  fsfc_fuse_ctrl u_fuse (
    .sys_clk_i    (sys_clk_i),
    .resetn_i     (resetn_i),
    .setup_wr_i   (setup_wr),
    .pulse_wr_i   (pulse_wr),
    .perm_en_i    (perm_reg),
    .wdata_i      (xdata_i.wdata),
    .burn_code_o  (burn_code_o),
    .burn_debug_o (burn_debug_o)
  );

  property p_pwe_clear;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      store && pwe_reg && !fc_wr |=> !pwe_reg;
  endproperty
  a_pwe_clear: assert property (p_pwe_clear) else $error("enable not cleared");

  property p_pwe_int;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      int_enabled_i && !store |=> $stable(pwe_reg);
  endproperty
  a_pwe_int: assert property (p_pwe_int) else $error("enable changed with interrupts on");

  property p_lock_hold;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      lock_reg |=> lock_reg;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock bit cleared");

  property p_read_block;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      lock_reg ##1 lock_reg |-> !ext_rd_grant_o;
  endproperty
  a_read_block: assert property (p_read_block) else $error("read granted while locked");

  property p_meen_once;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      meen_reg && !fc_wr |=> !meen_reg ##0 flash_o.mass_erase;
  endproperty
  a_meen_once: assert property (p_meen_once) else $error("erase enable persisted");

  property p_pin_read;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      xdata_i.rd && in_xsfr && xdata_i.addr == SECURITY_ADDR
        |=> xdata_rdata_o[SEC_PIN_BIT] == $past(sec_pin_i);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin level misreported");

  property p_ram_route;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      store && !pwe_reg |=> xram_wr_o && !flash_o.prog;
  endproperty
  a_ram_route: assert property (p_ram_route) else $error("store not sent to RAM");

  // fuse programming steps as seen on the external bus
  sequence s_setup_write;
    setup_wr && xdata_i.wdata == SETUP_VALUE;
  endsequence

  sequence s_no_fuse_write;
    !setup_wr && !pulse_wr;
  endsequence

  sequence s_select_write;
    pulse_wr && (xdata_i.wdata == SEL_CODE_FUSE || xdata_i.wdata == SEL_DEBUG_FUSE);
  endsequence

  sequence s_burn_write;
    pulse_wr && xdata_i.wdata == BURN_VALUE && perm_reg;
  endsequence

  // full arming sequence burns one fuse
  property p_burn_seq;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      s_setup_write ##1 s_no_fuse_write ##1 s_select_write ##1 s_no_fuse_write ##1 s_burn_write
        |=> burn_code_o ^ burn_debug_o;
  endproperty
  a_burn_seq: assert property (p_burn_seq) else $error("armed burn did not start");

  // enable write lands with interrupts off
  property p_pwe_load;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      fc_wr && !int_enabled_i && sfr_i.wdata[FC_PWE_BIT] |=> pwe_reg;
  endproperty
  a_pwe_load: assert property (p_pwe_load) else $error("enable write lost");

  property p_meen_hidden;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      sfr_i.rd && sfr_i.addr[7:0] == FLASH_CONTROL_ADDR |=> !sfr_rdata_o[FC_MEEN_BIT];
  endproperty
  a_meen_hidden: assert property (p_meen_hidden) else $error("erase enable read back");

  property p_lock_set;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      fc_wr && sfr_i.wdata[FC_LOCK_BIT] |=> lock_reg;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock bit not set");

  property p_read_grant;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      ext_rd_req_i && !lock_reg |=> ext_rd_grant_o;
  endproperty
  a_read_grant: assert property (p_read_grant) else $error("unlocked read refused");

  property p_perm_hidden;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      xdata_i.rd && in_xsfr && xdata_i.addr == SECURITY_ADDR |=> !xdata_rdata_o[SEC_PERM_BIT];
  endproperty
  a_perm_hidden: assert property (p_perm_hidden) else $error("enable bit read back");

  property p_fuse_sense;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      debug_fuse_blown_i |=> fuse_stat_reg[SEC_DEBUG_FUSE_BIT];
  endproperty
  a_fuse_sense: assert property (p_fuse_sense) else $error("blown fuse not shown");

  property p_xsfr_no_store;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      xdata_i.wr && in_xsfr |=> !xram_wr_o && !flash_o.prog;
  endproperty
  a_xsfr_no_store: assert property (p_xsfr_no_store) else $error("register write stored");

  property p_flash_capture;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      store |=> flash_o.addr == $past(xdata_i.addr) && flash_o.data == $past(xdata_i.wdata);
  endproperty
  a_flash_capture: assert property (p_flash_capture) else $error("store not captured");

  property p_unmapped;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      sfr_i.rd && sfr_i.addr[7:0] != FLASH_CONTROL_ADDR |=> sfr_rdata_o == UNMAPPED_READ;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : fsfc_top

/* rtl/fsfc_pkg.sv */
// fsfc_pkg: constants and carrier types for the flash security and fuse control block
// assumes the processor presents internal and external data register spaces with one-cycle strobes
package fsfc_pkg;
  localparam logic [7:0]  FLASH_CONTROL_ADDR   = 8'hb2;
  localparam logic [15:0] FUSE_BURN_PULSE_ADDR = 16'hffd1;
  localparam logic [15:0] FUSE_SETUP_ADDR      = 16'hffd2;
  localparam logic [15:0] SECURITY_ADDR        = 16'hffd7;
  localparam logic [15:0] XSFR_BASE            = 16'hfc00;
  localparam logic [15:0] XSFR_TOP             = 16'hffff;
  localparam int          FC_PWE_BIT           = 0;
  localparam int          FC_MEEN_BIT          = 1;
  localparam int          FC_LOCK_BIT          = 6;
  localparam int          SEC_CODE_FUSE_BIT    = 0;
  localparam int          SEC_DEBUG_FUSE_BIT   = 1;
  localparam int          SEC_PIN_BIT          = 5;
  localparam int          SEC_PERM_BIT         = 7;
  localparam logic [7:0]  BURN_VALUE           = 8'ha6;
  localparam logic [7:0]  SETUP_VALUE          = 8'h54;
  localparam logic [7:0]  SEL_CODE_FUSE        = 8'h81;
  localparam logic [7:0]  SEL_DEBUG_FUSE       = 8'h82;
  localparam logic [7:0]  REG_RESET            = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ        = 8'h00;
  localparam int          BURN_TIME_US         = 500;
  localparam int          CLK_MHZ              = 10;
  localparam int          BURN_CYCLES          = BURN_TIME_US * CLK_MHZ;
  localparam int          PAGE_BITS            = 9;

  // one register access from the processor
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fsfc_acc_s;

  // flash operations issued to the flash macro
  typedef struct packed {
    logic        prog;
    logic        mass_erase;
    logic [15:0] addr;
    logic [7:0]  data;
  } fsfc_flash_s;
endpackage : fsfc_pkg

/* rtl/fsfc_fuse_ctrl.sv */
// fsfc_fuse_ctrl: fuse set-up, selection and burn pulse control
// assumes write strobes are one-cycle pulses already decoded to each register
`timescale 1ns/1ns
module fsfc_fuse_ctrl
  import fsfc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       setup_wr_i,
  input  wire logic       pulse_wr_i,
  input  wire logic       perm_en_i,
  input  wire logic [7:0] wdata_i,
  output logic            burn_code_o,
  output logic            burn_debug_o
);
  typedef enum logic [1:0] {FS_IDLE, FS_ARMED, FS_SELECTED} fsfc_fuse_e;
  fsfc_fuse_e state_reg;
  logic [1:0] sel_reg;

  // set-up, then selection; only a set-up write of another value disarms
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= FS_IDLE;
      sel_reg   <= 2'h0;
    end else if (setup_wr_i) begin
      state_reg <= (wdata_i == SETUP_VALUE) ? FS_ARMED : FS_IDLE;
      sel_reg   <= 2'h0;
    end else if (state_reg == FS_ARMED && pulse_wr_i) begin
      if (wdata_i == SEL_CODE_FUSE) begin
        state_reg <= FS_SELECTED;
        sel_reg   <= 2'h1;
      end else if (wdata_i == SEL_DEBUG_FUSE) begin
        state_reg <= FS_SELECTED;
        sel_reg   <= 2'h2;
      end
    end
  end

  // burn pulse drives the chosen fuse until any other value is written or perm_en_i drops
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      burn_code_o  <= 1'b0;
      burn_debug_o <= 1'b0;
    end else if (pulse_wr_i) begin
      burn_code_o  <= (wdata_i == BURN_VALUE) && perm_en_i && (state_reg == FS_SELECTED)
                      && sel_reg[0];
      burn_debug_o <= (wdata_i == BURN_VALUE) && perm_en_i && (state_reg == FS_SELECTED)
                      && sel_reg[1];
    end else if (!perm_en_i) begin
      burn_code_o  <= 1'b0;
      burn_debug_o <= 1'b0;
    end
  end

  property p_burn_stop;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      pulse_wr_i && wdata_i != BURN_VALUE |=> !burn_code_o && !burn_debug_o;
  endproperty
  a_burn_stop: assert property (p_burn_stop) else $error("burn did not stop");

  property p_burn_gate;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      $rose(burn_code_o || burn_debug_o) |-> $past(perm_en_i) && $past(state_reg) == FS_SELECTED;
  endproperty
  a_burn_gate: assert property (p_burn_gate) else $error("burn without arming");

  property p_one_fuse;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !(burn_code_o && burn_debug_o);
  endproperty
  a_one_fuse: assert property (p_one_fuse) else $error("two fuses burning");
endmodule : fsfc_fuse_ctrl

/* rtl/fsfc_flash_gate.sv */
// fsfc_flash_gate: routes data-pointer stores to flash and applies the lock
// assumes stores and debug requests are one-cycle pulses
`timescale 1ns/1ns
module fsfc_flash_gate
  import fsfc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        pwe_i,
  input  wire logic        lock_i,
  input  wire logic        store_i,
  input  wire logic [15:0] store_addr_i,
  input  wire logic [7:0]  store_data_i,
  input  wire logic        dbg_wr_i,
  input  wire logic [15:0] dbg_addr_i,
  input  wire logic [7:0]  dbg_data_i,
  output logic             cpu_prog_o,
  output logic             dbg_prog_o
);
  logic cpu_page0;
  logic dbg_page0;

  // page zero spans the low addresses below the first page boundary
  assign cpu_page0 = (store_addr_i >> PAGE_BITS) == 16'h0000;
  assign dbg_page0 = (dbg_addr_i >> PAGE_BITS) == 16'h0000;

  // accepted programming strobes, one cycle each
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_prog_o <= 1'b0;
      dbg_prog_o <= 1'b0;
    end else begin
      cpu_prog_o <= store_i && pwe_i && !(lock_i && cpu_page0);
      dbg_prog_o <= dbg_wr_i && !(lock_i && dbg_page0);
    end
  end

  property p_page0;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      lock_i && ((store_i && cpu_page0) || (dbg_wr_i && dbg_page0))
        |=> !(cpu_prog_o && $past(store_i)) && !(dbg_prog_o && $past(dbg_wr_i));
  endproperty
  a_page0: assert property (p_page0) else $error("page zero written while locked");

  property p_no_route;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      store_i && !pwe_i |=> !cpu_prog_o;
  endproperty
  a_no_route: assert property (p_no_route) else $error("store reached flash without enable");
endmodule : fsfc_flash_gate

/* dv/tb.sv */
// tb: self-checking bench for fsfc_top, register and store accesses by task calls
// assumes the design package is compiled first and that stores below 0xfc00 reach flash or RAM, except page-zero stores while locked
`timescale 1ns/1ns
module tb
  import fsfc_pkg::*;
;
  logic        sys_clk_i          = 1'b0;
  logic        resetn_i           = 1'b0;
  fsfc_acc_s   sfr_i              = '0;
  fsfc_acc_s   xdata_i            = '0;
  logic        int_enabled_i      = 1'b0;
  logic        sec_pin_i          = 1'b0;
  logic        code_fuse_blown_i  = 1'b0;
  logic        debug_fuse_blown_i = 1'b0;
  logic        ext_rd_req_i       = 1'b0;
  logic        dbg_wr_i           = 1'b0;
  logic [15:0] dbg_addr_i         = '0;
  logic [7:0]  dbg_data_i         = 8'h00;
  logic [7:0]  sfr_rdata_o;
  logic [7:0]  xdata_rdata_o;
  logic        xram_wr_o;
  fsfc_flash_s flash_o;
  logic        dbg_prog_o;
  logic        ext_rd_grant_o;
  logic        burn_code_o;
  logic        burn_debug_o;
  int          failures    = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  logic [7:0]  sel [2]     = '{SEL_CODE_FUSE, SEL_DEBUG_FUSE};
  logic [7:0]  stp [2]     = '{8'h00, 8'h5a};

  fsfc_top dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sfr_i(sfr_i), .xdata_i(xdata_i),
    .int_enabled_i(int_enabled_i), .sec_pin_i(sec_pin_i),
    .code_fuse_blown_i(code_fuse_blown_i), .debug_fuse_blown_i(debug_fuse_blown_i),
    .ext_rd_req_i(ext_rd_req_i), .dbg_wr_i(dbg_wr_i), .dbg_addr_i(dbg_addr_i),
    .dbg_data_i(dbg_data_i), .sfr_rdata_o(sfr_rdata_o), .xdata_rdata_o(xdata_rdata_o),
    .xram_wr_o(xram_wr_o), .flash_o(flash_o), .dbg_prog_o(dbg_prog_o),
    .ext_rd_grant_o(ext_rd_grant_o), .burn_code_o(burn_code_o), .burn_debug_o(burn_debug_o)
  );

  // 10 MHz clock
  always #50 sys_clk_i = ~sys_clk_i;

  // prints counts and verdict, then stops the run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // hang guard, well above the length of the sequence
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2 * BURN_CYCLES + 2000) begin
      failures = failures + 1;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one access: strobe held for one edge, outputs looked at just after it
  task automatic acc(input bit xsp, input bit wr, input logic [15:0] a, input logic [7:0] d);
    fsfc_acc_s req;
    req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge sys_clk_i);
    if (xsp) xdata_i <= req;
    else sfr_i <= req;
    @(posedge sys_clk_i);
    sfr_i   <= '0;
    xdata_i <= '0;
    #1;
  endtask : acc

  task automatic rd_s(input string what, input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, 1'b0, {8'h00, a}, 8'h00);
    chk(what, exp, sfr_rdata_o);
  endtask : rd_s

  task automatic rd_x(input string what, input logic [15:0] a, input logic [7:0] exp);
    acc(1'b1, 1'b0, a, 8'h00);
    chk(what, exp, xdata_rdata_o);
  endtask : rd_x

  // debug port write, acceptance seen in the cycle after
  task automatic dbg(input logic [15:0] a, input logic exp);
    @(posedge sys_clk_i);
    dbg_wr_i   <= 1'b1;
    dbg_addr_i <= a;
    @(posedge sys_clk_i);
    dbg_wr_i <= 1'b0;
    #1;
    chk("dbg_prog", exp, dbg_prog_o);
  endtask : dbg

  task automatic wait_edges(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wait_edges

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd_s("flash_control reset", FLASH_CONTROL_ADDR, REG_RESET);
    rd_x("security reset", SECURITY_ADDR, 8'h00);
    // enable bit refused while interrupts on
    @(posedge sys_clk_i);
    int_enabled_i <= 1'b1;
    acc(1'b0, 1'b1, 16'h00b2, 8'h01);
    rd_s("pwe masked", FLASH_CONTROL_ADDR, 8'h00);
    @(posedge sys_clk_i);
    int_enabled_i <= 1'b0;
    acc(1'b0, 1'b1, 16'h00b2, 8'h01);
    rd_s("pwe set", FLASH_CONTROL_ADDR, 8'h01);
    acc(1'b1, 1'b1, 16'h1234, 8'h5a);
    chk("flash prog", 1'b1, flash_o.prog);
    chk("flash addr data", 16'h5a34, {flash_o.data, flash_o.addr[7:0]});
    chk("ram store", 1'b0, xram_wr_o);
    rd_s("pwe cleared", FLASH_CONTROL_ADDR, 8'h00);
    acc(1'b1, 1'b1, 16'h0100, 8'h3c);
    chk("ram store", 1'b1, xram_wr_o);
    chk("flash prog", 1'b0, flash_o.prog);
    // mass erase one-shot, bit reads back zero
    acc(1'b0, 1'b1, 16'h00b2, 8'h02);
    chk("erase early", 1'b0, flash_o.mass_erase);
    wait_edges(1);
    chk("erase pulse", 1'b1, flash_o.mass_erase);
    wait_edges(1);
    chk("erase end", 1'b0, flash_o.mass_erase);
    rd_s("meen write-only", FLASH_CONTROL_ADDR, 8'h00);
    // unmapped register location
    rd_s("unmapped read", 8'h90, UNMAPPED_READ);
    acc(1'b0, 1'b1, 16'h0090, 8'hff);
    rd_s("unmapped write", FLASH_CONTROL_ADDR, 8'h00);
    // security status bits and pin, pin kept high for the rest of the run
    @(posedge sys_clk_i);
    sec_pin_i <= 1'b1;
    rd_x("pin high", SECURITY_ADDR, 8'h20);
    acc(1'b1, 1'b1, SECURITY_ADDR, 8'h03);
    rd_x("fuse status", SECURITY_ADDR, 8'h23);
    acc(1'b1, 1'b1, SECURITY_ADDR, 8'h00);
    @(posedge sys_clk_i);
    debug_fuse_blown_i <= 1'b1;
    rd_x("fuse sensed", SECURITY_ADDR, 8'h22);
    @(posedge sys_clk_i);
    debug_fuse_blown_i <= 1'b0;
    acc(1'b1, 1'b1, SECURITY_ADDR, 8'h00);
    rd_x("status cleared", SECURITY_ADDR, 8'h20);
    // burn value ignored without permanent programming
    acc(1'b1, 1'b1, FUSE_SETUP_ADDR, SETUP_VALUE);
    chk("register not ram", 1'b0, xram_wr_o);
    acc(1'b1, 1'b1, FUSE_BURN_PULSE_ADDR, SEL_CODE_FUSE);
    acc(1'b1, 1'b1, FUSE_BURN_PULSE_ADDR, BURN_VALUE);
    wait_edges(1);
    chk("burn without perm", 2'b00, {burn_debug_o, burn_code_o});
    acc(1'b1, 1'b1, FUSE_BURN_PULSE_ADDR, 8'h00);
    acc(1'b1, 1'b1, SECURITY_ADDR, 8'h80);
    rd_x("perm write-only", SECURITY_ADDR, 8'h20);
    // each fuse burned, stopped by a different value
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 1'b1, FUSE_SETUP_ADDR, SETUP_VALUE);
      acc(1'b1, 1'b1, FUSE_BURN_PULSE_ADDR, sel[i]);
      acc(1'b1, 1'b1, FUSE_BURN_PULSE_ADDR, BURN_VALUE);
      wait_edges(BURN_CYCLES);
      chk("burn on", {i[0], !i[0]}, {burn_debug_o, burn_code_o});
      acc(1'b1, 1'b1, FUSE_BURN_PULSE_ADDR, stp[i]);
      wait_edges(1);
      chk("burn off", 2'b00, {burn_debug_o, burn_code_o});
    end
    acc(1'b1, 1'b1, FUSE_SETUP_ADDR, SETUP_VALUE);
    acc(1'b1, 1'b1, FUSE_BURN_PULSE_ADDR, SEL_CODE_FUSE);
    acc(1'b1, 1'b1, FUSE_BURN_PULSE_ADDR, BURN_VALUE);
    acc(1'b1, 1'b1, SECURITY_ADDR, 8'h00);
    wait_edges(1);
    chk("burn perm cleared", 1'b0, burn_code_o);
    // before the lock: debug and external reads allowed
    dbg(16'h0010, 1'b1);
    @(posedge sys_clk_i);
    ext_rd_req_i <= 1'b1;
    wait_edges(2);
    chk("read grant", 1'b1, ext_rd_grant_o);
    // lock is set-only
    acc(1'b0, 1'b1, 16'h00b2, 8'h40);
    rd_s("lock set", FLASH_CONTROL_ADDR, 8'h40);
    acc(1'b0, 1'b1, 16'h00b2, 8'h00);
    rd_s("lock kept", FLASH_CONTROL_ADDR, 8'h40);
    wait_edges(2);
    chk("read blocked", 1'b0, ext_rd_grant_o);
    @(posedge sys_clk_i);
    ext_rd_req_i <= 1'b0;
    // page zero writes refused, page one allowed
    acc(1'b0, 1'b1, 16'h00b2, 8'h41);
    acc(1'b1, 1'b1, 16'h01ff, 8'h77);
    chk("page zero store", 1'b0, flash_o.prog);
    acc(1'b0, 1'b1, 16'h00b2, 8'h41);
    acc(1'b1, 1'b1, 16'h0200, 8'h77);
    chk("page one store", 1'b1, flash_o.prog);
    dbg(16'h01ff, 1'b0);
    dbg(16'h0200, 1'b1);
    // only reset clears the lock
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd_s("lock after reset", FLASH_CONTROL_ADDR, 8'h00);
    test_done();
  end
endmodule : tb
